/* testbench.sv */
// Self-checking bench for the framer with a host model on the UART streams.
// Assumes the checker binds itself; the link timer is shortened by parameters.
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock, rst, rx_valid, rx_ready, tx_valid, tx_ready, uart_en, cts_n, rts_n, slow;
   logic hdr_valid, pay_valid, pay_ready, frame_ok, frame_err, snd_valid, snd_ready, sp_valid, sp_ready;
   logic remote_rx, radio_link, link_lost, cfg_load, evt_std_en, evt_link_en, slow_clk_ok, passthru, evt_pending;
   logic radio_scan, pt_in_ready;
   logic [7:0] rx_data, tx_data, pay_data, sp_data, pt_in_data;
   logic [1:0] cfg_evlvl, cfg_inq;
   uhf_pkg::uhf_hdr_s hdr, snd_hdr, exp_hdr, last_hdr;
   uhf_pkg::uhf_power_e power_state;
   uhf_pkg::uhf_inq_e inq_mode;
   logic [7:0] exp_tx[$], exp_pay[$], got_pay[$];
   logic [7:0] types[4] = '{uhf_pkg::TYPE_REQ, uhf_pkg::TYPE_CFM, uhf_pkg::TYPE_IND, uhf_pkg::TYPE_RES};
   int seed, bad_count, comparisons, n_ok, n_err, n_lost;
   uhf_framer #(.TICK_CYCLES(4), .LINK_TIMEOUT_MS(3)) DUT (.clock, .rst, .rx_valid, .rx_data, .rx_ready,
      .tx_valid, .tx_data, .tx_ready, .uart_en, .cts_n, .rts_n, .passthru, .pt_out_valid(), .pt_out_data(),
      .pt_out_ready(1'b1), .pt_in_valid(1'b0), .pt_in_data, .pt_in_ready, .hdr_valid, .hdr, .pay_valid,
      .pay_data, .pay_ready, .frame_ok, .frame_err, .snd_valid, .snd_hdr, .snd_ready, .sp_valid, .sp_data,
      .sp_ready, .evt_pending, .radio_scan, .radio_link, .power_state, .slow_clk_ok, .remote_rx,
      .link_lost, .cfg_load, .cfg_evlvl, .cfg_inq, .evt_std_en, .evt_link_en, .inq_mode);
   uhf_host_model HOST (.clock, .slow, .rx_valid, .rx_data, .rx_ready, .tx_valid, .tx_data, .tx_ready);
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   always @(posedge clock) begin
      if (hdr_valid) last_hdr = hdr;
      if (pay_valid && pay_ready) got_pay.push_back(pay_data);
      n_ok += frame_ok;
      n_err += frame_err;
      n_lost += link_lost;
      #1;
      pay_ready = 1'($random(seed));
      slow = 1'($random(seed));
      pt_in_data = 8'($random(seed));
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("BAD at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   // The host sends one frame; a nonzero bad spoils the checksum.
   task automatic put_frame(input logic [7:0] t, input logic [7:0] o, input int n, input logic [7:0] bad);
      logic [7:0] b[$];
      b = {8'h02, t, o, 8'(n), 8'(n >> 8), 8'(t + o + (n & 255) + (n >> 8)) ^ bad};
      for (int i = 0; i < n; i++) begin
         b.push_back(8'($random(seed)));
         exp_pay.push_back(b[$]);
      end
      if (bad == 8'h00) exp_hdr = '{t, o, 16'(n)};
      b.push_back(8'h03);
      HOST.send_q = {HOST.send_q, b};
   endtask
   // The core asks for a frame; requests are held until the ready edge.
   task automatic core_send(input logic [7:0] t, input logic [7:0] o, input int n);
      snd_hdr = '{t, o, 16'(n)};
      snd_valid = 1'b1;
      exp_tx = {8'h02, t, o, 8'(n), 8'(n >> 8), 8'(t + o + (n & 255) + (n >> 8))};
      do @(posedge clock); while (snd_ready !== 1'b1);
      #1 snd_valid = 1'b0;
      for (int i = 0; i < n; i++) begin
         sp_data = 8'($random(seed));
         sp_valid = 1'b1;
         exp_tx.push_back(sp_data);
         do @(posedge clock); while (sp_ready !== 1'b1);
         #1;
      end
      sp_valid = 1'b0;
      exp_tx.push_back(8'h03);
   endtask
   task automatic check_tx();
      for (int k = 0; k < 2000 && HOST.seen_q.size() < exp_tx.size(); k++) @(posedge clock);
      #1;
      foreach (exp_tx[i]) check(HOST.seen_q[i], exp_tx[i]);
      HOST.seen_q = {};
   endtask
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   initial begin
      repeat (6000) @(posedge clock);
      bad_count++;
      give_verdict();
   end
   initial begin
      seed = 3588;
      {rst, cts_n} = 2'b11;
      {snd_valid, sp_valid, remote_rx, radio_link, cfg_load, pay_ready, slow, passthru, evt_pending, radio_scan} = '0;
      {sp_data, pt_in_data, snd_hdr, cfg_evlvl, cfg_inq} = '0;
      {bad_count, comparisons, n_ok, n_err, n_lost} = '0;
      repeat (2) @(posedge clock);
      #1 rst = 1'b0;
      check({uart_en, rts_n}, 2'b10);
      check({power_state, slow_clk_ok}, {uhf_pkg::power_state_uart_only, 1'b0});
      check({evt_std_en, evt_link_en, inq_mode}, {2'b10, uhf_pkg::INQ_DEFAULT});
      $display("test reset done");
      // The spoiled middle frame must be dropped and the third one still found.
      put_frame(uhf_pkg::TYPE_REQ, 8'h11, 1, 8'h00);
      put_frame(uhf_pkg::TYPE_REQ, 8'h12, 0, 8'h5A);
      put_frame(uhf_pkg::TYPE_REQ, 8'($random(seed)) & 8'h3F, 3, 8'h00);
      for (int k = 0; k < 500 && n_ok + n_err < 3; k++) @(posedge clock);
      #1;
      check({n_ok[3:0], n_err[3:0]}, 8'h21);
      check(last_hdr, exp_hdr);
      check(got_pay.size(), 4);
      foreach (exp_pay[i]) check(got_pay[i], exp_pay[i]);
      $display("test receive done");
      foreach (types[i]) begin
         core_send(types[i], 8'(i + 1), i);
         check_tx();
      end
      $display("test transmit done");
      // Disable: confirm goes out before the transport drops.
      put_frame(uhf_pkg::TYPE_REQ, uhf_pkg::OPC_DISABLE_TL, 0, 8'h00);
      exp_tx = {8'h02, 8'h43, 8'h4F, 8'h00, 8'h00, 8'h92, 8'h03};
      check_tx();
      for (int k = 0; k < 100 && uart_en !== 1'b0; k++) @(posedge clock);
      @(posedge clock);
      #1;
      check({uart_en, rts_n}, 2'b01);
      cts_n = 1'b0;
      exp_tx = {8'h02, 8'h69, 8'h50, 8'h00, 8'h00, 8'hB9, 8'h03};
      check_tx();
      check({uart_en, rts_n}, 2'b10);
      put_frame(uhf_pkg::TYPE_REQ, 8'h20, 0, 8'h00);
      for (int k = 0; k < 200 && n_ok < 4; k++) @(posedge clock);
      #1;
      check(n_ok, 4);
      $display("test transport done");
      for (int k = 0; k < 3; k++) begin
         {cfg_evlvl, cfg_inq, cfg_load} = {2'(k), 2'(k), 1'b1};
         @(posedge clock);
         #1 cfg_load = 1'b0;
         @(posedge clock);
         #1;
         check({evt_std_en, evt_link_en, inq_mode}, {k != 0, k == 2, 2'(k)});
      end
      // A remote packet restarts the link timer, so the loss comes later and only once.
      {radio_scan, radio_link} = 2'b11;
      repeat (7) @(posedge clock);
      #1 remote_rx = 1'b1;
      @(posedge clock);
      #1 remote_rx = 1'b0;
      repeat (7) @(posedge clock);
      #1;
      check({power_state, n_lost[3:0]}, {uhf_pkg::power_state_link_uart_on, 4'h0});
      repeat (40) @(posedge clock);
      #1;
      check(n_lost, 1);
      $display("test config and link done");
      give_verdict();
   end
endmodule // testbench
`default_nettype wire

/* uhf_buf2.sv */
// Two-entry byte buffer with valid and ready on both sides.
// Assumes the same clock on both sides; a stalled drain side fills it.
`default_nettype none
module uhf_buf2 #(
   parameter int W = 8
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic in_valid,
   input wire logic [W-1:0] in_data,
   output logic in_ready,
   output logic out_valid,
   output logic [W-1:0] out_data,
   input wire logic out_ready
);
   if (W < 1) begin : g_bad_w
      $error("uhf_buf2: width must be at least one");
   end

   logic [W-1:0] mem_ff [2]; // Storage slots.
   logic rd_ff; // Slot read next.
   logic wr_ff; // Slot written next.
   logic [1:0] cnt_ff; // Words held.
   wire push = in_valid & in_ready;
   wire pop = out_valid & out_ready;

   // Full and empty come straight from the count, so they never lie.
   assign in_ready = (cnt_ff != 2'h2);
   assign out_valid = (cnt_ff != 2'h0);
   assign out_data = mem_ff[rd_ff];

   // Data slots need no reset; only pointers and count do.
   always_ff @(posedge clock) begin
      if (push) begin
         mem_ff[wr_ff] <= in_data;
      end
   end

   // Pointer and count update.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rd_ff <= 1'b0;
         wr_ff <= 1'b0;
         cnt_ff <= 2'h0;
      end else begin
         if (push) wr_ff <= ~wr_ff;
         if (pop) rd_ff <= ~rd_ff;
         cnt_ff <= cnt_ff + {1'b0, push} - {1'b0, pop};
      end
   end
endmodule // uhf_buf2
`default_nettype wire

/* uhf_framer.sv */
// Command framer of a serial radio module's host port, with transport control.
// Assumes byte streams from and to a UART, and a command core beside it.
`default_nettype none
module uhf_framer #(
   parameter int TICK_CYCLES = uhf_pkg::TICK_CYCLES,
   parameter int LINK_TIMEOUT_MS = uhf_pkg::LINK_TIMEOUT_MS
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic rx_valid,
   input wire logic [7:0] rx_data,
   output logic rx_ready,
   output logic tx_valid,
   output logic [7:0] tx_data,
   input wire logic tx_ready,
   output logic uart_en,
   input wire logic cts_n,
   output logic rts_n,
   input wire logic passthru,
   output logic pt_out_valid,
   output logic [7:0] pt_out_data,
   input wire logic pt_out_ready,
   input wire logic pt_in_valid,
   input wire logic [7:0] pt_in_data,
   output logic pt_in_ready,
   output logic hdr_valid,
   output uhf_pkg::uhf_hdr_s hdr,
   output logic pay_valid,
   output logic [7:0] pay_data,
   input wire logic pay_ready,
   output logic frame_ok,
   output logic frame_err,
   input wire logic snd_valid,
   input wire uhf_pkg::uhf_hdr_s snd_hdr,
   output logic snd_ready,
   input wire logic sp_valid,
   input wire logic [7:0] sp_data,
   output logic sp_ready,
   input wire logic evt_pending,
   input wire logic radio_scan,
   input wire logic radio_link,
   output uhf_pkg::uhf_power_e power_state,
   output logic slow_clk_ok,
   input wire logic remote_rx,
   output logic link_lost,
   input wire logic cfg_load,
   input wire logic [1:0] cfg_evlvl,
   input wire logic [1:0] cfg_inq,
   output logic evt_std_en,
   output logic evt_link_en,
   output uhf_pkg::uhf_inq_e inq_mode
);
   if (TICK_CYCLES < 2 || LINK_TIMEOUT_MS < 1) begin : g_bad_par
      $error("uhf_framer: tick and timeout counts must be positive");
   end

   localparam int TW = $clog2(TICK_CYCLES);
   localparam int MW = $clog2(LINK_TIMEOUT_MS + 1);

   typedef enum logic [2:0] {R_HUNT, R_TYPE, R_OPC, R_LENL, R_LENH, R_SUM, R_PAY, R_END} uhf_rx_e;
   typedef enum logic [3:0] {T_IDLE, T_START, T_TYPE, T_OPC, T_LENL, T_LENH, T_SUM, T_PAY, T_END} uhf_tx_e;
   typedef enum logic [2:0] {TL_ON, TL_DRAIN, TL_CFM, TL_FLUSH, TL_OFF, TL_WAKE, TL_ANN} uhf_tl_e;

   // Receive side state.
   uhf_rx_e rx_st_ff, nxt_rx_st;
   uhf_pkg::uhf_hdr_s rh_ff, nxt_rh; // Header being collected.
   logic [15:0] rcnt_ff, nxt_rcnt; // Payload bytes still due.
   logic hv_ff, nxt_hv; // Header accepted pulse.
   logic ok_ff, nxt_ok; // Frame good pulse.
   logic err_ff, nxt_err; // Frame dropped pulse.
   logic dis_ff, nxt_dis; // Disable-transport request seen.
   logic ov_ff, nxt_ov; // Output byte stage holds a byte.
   logic opt_ff, nxt_opt; // That byte is pass-through data.
   logic [7:0] ob_ff, nxt_ob; // Output byte stage.
   logic pass_ff; // Pass-through in force.

   // Transmit side state.
   uhf_tx_e tx_st_ff, nxt_tx_st;
   uhf_pkg::uhf_hdr_s th_ff, nxt_th; // Header being sent.
   logic [15:0] tcnt_ff, nxt_tcnt; // Payload bytes still to send.
   uhf_tl_e tl_st_ff, nxt_tl_st;
   logic rts_n_ff, nxt_rts_n;
   logic cts_d_ff; // Previous CTS level for the edge test.

   // Timeout, power and configuration state.
   logic [TW-1:0] tick_ff;
   logic [MW-1:0] ms_ff;
   logic lost_ff; // Timeout already reported.
   logic lost_p_ff; // One-cycle link-lost pulse.
   uhf_pkg::uhf_power_e pwr_ff, nxt_pwr;
   uhf_pkg::uhf_evlvl_e lvl_ff;
   uhf_pkg::uhf_inq_e inq_ff;

   // Buffer wiring.
   logic b_in_valid, b_in_ready, b_out_valid;
   logic [7:0] b_in_data;

   // UART runs except while disabled or while waiting for the host to answer.
   assign uart_en = (tl_st_ff != TL_OFF) && (tl_st_ff != TL_WAKE);
   assign rts_n = rts_n_ff;

   // Receive handshake: data bytes need room in the output stage.
   wire data_byte = pass_ff || (rx_st_ff == R_PAY);
   wire o_drain = opt_ff ? pt_out_ready : pay_ready;
   wire o_room = !ov_ff || o_drain;
   assign rx_ready = uart_en && (!data_byte || o_room);
   wire rx_take = rx_valid && rx_ready;
   wire [7:0] rsum = uhf_pkg::hdr_sum(rh_ff);
   wire len_ok = (rh_ff.len <= uhf_pkg::MAX_PAYLOAD);

   assign pay_valid = ov_ff && !opt_ff;
   assign pt_out_valid = ov_ff && opt_ff;
   assign pay_data = ob_ff;
   assign pt_out_data = ob_ff;
   assign hdr = rh_ff;
   assign hdr_valid = hv_ff;
   assign frame_ok = ok_ff;
   assign frame_err = err_ff;

   // Receive parser. A bad checksum or length drops the frame at the
   // checksum byte, so no payload of a frame with a bad checksum or length reaches the core.
   always_comb begin
      nxt_rx_st = rx_st_ff;
      nxt_rh = rh_ff;
      nxt_rcnt = rcnt_ff;
      nxt_hv = 1'b0;
      nxt_ok = 1'b0;
      nxt_err = 1'b0;
      nxt_dis = 1'b0;
      nxt_ov = ov_ff && !o_drain;
      nxt_opt = opt_ff;
      nxt_ob = ob_ff;
      if (pass_ff) begin
         // Raw bytes go straight to the link, never parsed.
         nxt_rx_st = R_HUNT;
         if (rx_take) begin
            nxt_ov = 1'b1;
            nxt_opt = 1'b1;
            nxt_ob = rx_data;
         end
      end else if (rx_take) begin
         case (rx_st_ff)
            R_HUNT: begin
               if (rx_data == uhf_pkg::DELIM_START) nxt_rx_st = R_TYPE;
            end
            R_TYPE: begin
               nxt_rh.ptype = rx_data;
               nxt_rx_st = R_OPC;
            end
            R_OPC: begin
               nxt_rh.opcode = rx_data;
               nxt_rx_st = R_LENL;
            end
            R_LENL: begin
               nxt_rh.len[7:0] = rx_data;
               nxt_rx_st = R_LENH;
            end
            R_LENH: begin
               nxt_rh.len[15:8] = rx_data;
               nxt_rx_st = R_SUM;
            end
            R_SUM: begin
               if (rx_data == rsum && len_ok) begin
                  nxt_hv = 1'b1;
                  nxt_rcnt = rh_ff.len;
                  nxt_rx_st = (rh_ff.len == 16'h0000) ? R_END : R_PAY;
               end else begin
                  nxt_err = 1'b1;
                  nxt_rx_st = R_HUNT;
               end
            end
            R_PAY: begin
               nxt_ov = 1'b1;
               nxt_opt = 1'b0;
               nxt_ob = rx_data;
               nxt_rcnt = rcnt_ff - 16'h0001;
               if (rcnt_ff == 16'h0001) nxt_rx_st = R_END;
            end
            default: begin
               // A missing end byte throws the frame away.
               nxt_rx_st = R_HUNT;
               if (rx_data == uhf_pkg::DELIM_END) begin
                  nxt_ok = 1'b1;
                  nxt_dis = (rh_ff.ptype == uhf_pkg::TYPE_REQ) && (rh_ff.opcode == uhf_pkg::OPC_DISABLE_TL);
               end else begin
                  nxt_err = 1'b1;
               end
            end
         endcase
      end
   end

   // Internal transport frames carry no payload and take the framer first.
   wire int_req = (tl_st_ff == TL_CFM) || (tl_st_ff == TL_ANN);
   uhf_pkg::uhf_hdr_s int_hdr;
   assign int_hdr.ptype = (tl_st_ff == TL_CFM) ? uhf_pkg::TYPE_CFM : uhf_pkg::TYPE_IND;
   assign int_hdr.opcode = (tl_st_ff == TL_CFM) ? uhf_pkg::OPC_DISABLE_TL : uhf_pkg::OPC_TL_ENABLED;
   assign int_hdr.len = 16'h0000;

   // Core frames are taken only with the transport up and no pass-through.
   assign snd_ready = (tx_st_ff == T_IDLE) && !int_req && (tl_st_ff == TL_ON) && !pass_ff;
   wire t_adv = b_in_ready && (tx_st_ff != T_IDLE) && (tx_st_ff != T_PAY);
   wire t_done = (tx_st_ff == T_END) && b_in_ready;
   wire [7:0] tsum = uhf_pkg::hdr_sum(th_ff);
   assign sp_ready = (tx_st_ff == T_PAY) && b_in_ready;
   assign pt_in_ready = pass_ff && b_in_ready;

   // Byte offered to the buffer, per framer step; same layout both ways.
   wire [7:0] t_byte = (tx_st_ff == T_START) ? uhf_pkg::DELIM_START
                     : (tx_st_ff == T_TYPE) ? th_ff.ptype
                     : (tx_st_ff == T_OPC) ? th_ff.opcode
                     : (tx_st_ff == T_LENL) ? th_ff.len[7:0]
                     : (tx_st_ff == T_LENH) ? th_ff.len[15:8]
                     : (tx_st_ff == T_SUM) ? tsum
                     : (tx_st_ff == T_PAY) ? sp_data
                     : uhf_pkg::DELIM_END;
   wire t_valid = (tx_st_ff == T_PAY) ? sp_valid : (tx_st_ff != T_IDLE);
   assign b_in_valid = pass_ff ? pt_in_valid : t_valid;
   assign b_in_data = pass_ff ? pt_in_data : t_byte;

   // Transmit framer sequence.
   always_comb begin
      nxt_tx_st = tx_st_ff;
      nxt_th = th_ff;
      nxt_tcnt = tcnt_ff;
      case (tx_st_ff)
         T_IDLE: begin
            if (int_req) begin
               nxt_th = int_hdr;
               nxt_tx_st = T_START;
            end else if (snd_valid && snd_ready) begin
               nxt_th = snd_hdr;
               nxt_tx_st = T_START;
            end
         end
         T_SUM: begin
            nxt_tcnt = th_ff.len;
            if (t_adv) nxt_tx_st = (th_ff.len == 16'h0000) ? T_END : T_PAY;
         end
         T_PAY: begin
            if (sp_valid && sp_ready) begin
               nxt_tcnt = tcnt_ff - 16'h0001;
               if (tcnt_ff == 16'h0001) nxt_tx_st = T_END;
            end
         end
         T_END: begin
            if (t_adv) nxt_tx_st = T_IDLE;
         end
         default: begin
            if (t_adv) nxt_tx_st = uhf_tx_e'(tx_st_ff + 4'h1);
         end
      endcase
   end

   // Transport-layer control and the wake-up handshake on RTS and CTS.
   wire cts_fall = cts_d_ff && !cts_n;
   wire tx_empty = (tx_st_ff == T_IDLE) && !b_out_valid;
   always_comb begin
      nxt_tl_st = tl_st_ff;
      nxt_rts_n = rts_n_ff;
      case (tl_st_ff)
         TL_ON: begin
            nxt_rts_n = 1'b0;
            if (dis_ff) nxt_tl_st = TL_DRAIN;
         end
         TL_DRAIN: begin
            if (tx_empty) nxt_tl_st = TL_CFM;
         end
         TL_CFM: begin
            if (t_done) nxt_tl_st = TL_FLUSH;
         end
         TL_FLUSH: begin
            // The confirm must leave the wire before the UART stops.
            if (tx_empty) begin
               nxt_tl_st = TL_OFF;
               nxt_rts_n = 1'b1;
            end
         end
         TL_OFF: begin
            if (cts_fall) begin
               nxt_tl_st = TL_ANN;
               nxt_rts_n = 1'b0;
            end else if (evt_pending) begin
               nxt_tl_st = TL_WAKE;
               nxt_rts_n = 1'b0;
            end
         end
         TL_WAKE: begin
            if (!cts_n) nxt_tl_st = TL_ANN;
         end
         default: begin
            // Announcement goes out before any core frame or event.
            if (t_done) nxt_tl_st = TL_ON;
         end
      endcase
   end

   // Power state from UART and radio activity; a link outranks scanning.
   always_comb begin
      if (radio_link) begin
         nxt_pwr = uart_en ? uhf_pkg::power_state_link_uart_on : uhf_pkg::power_state_link_uart_off;
      end else if (radio_scan) begin
         nxt_pwr = uart_en ? uhf_pkg::power_state_scan_uart_on : uhf_pkg::power_state_scan_uart_off;
      end else begin
         nxt_pwr = uart_en ? uhf_pkg::power_state_uart_only : uhf_pkg::power_state_all_off;
      end
   end
   assign power_state = pwr_ff;
   assign slow_clk_ok = (pwr_ff == uhf_pkg::power_state_scan_uart_off);

   // Event level and inquiry mode decoding.
   assign evt_std_en = (lvl_ff != uhf_pkg::EV_NONE);
   assign evt_link_en = (lvl_ff == uhf_pkg::EV_ALL);
   assign inq_mode = inq_ff;
   assign link_lost = lost_p_ff;
   wire tick = (tick_ff == TW'(TICK_CYCLES - 1));
   wire ms_full = (ms_ff == MW'(LINK_TIMEOUT_MS));

   // Receive registers.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         rx_st_ff <= R_HUNT;
         rh_ff <= '0;
         rcnt_ff <= 16'h0000;
         hv_ff <= 1'b0;
         ok_ff <= 1'b0;
         err_ff <= 1'b0;
         dis_ff <= 1'b0;
         ov_ff <= 1'b0;
         opt_ff <= 1'b0;
         ob_ff <= 8'h00;
      end else begin
         rx_st_ff <= nxt_rx_st;
         rh_ff <= nxt_rh;
         rcnt_ff <= nxt_rcnt;
         hv_ff <= nxt_hv;
         ok_ff <= nxt_ok;
         err_ff <= nxt_err;
         dis_ff <= nxt_dis;
         ov_ff <= nxt_ov;
         opt_ff <= nxt_opt;
         ob_ff <= nxt_ob;
      end
   end

   // Mode switches only between frames in both directions, but a frame that starts on
   // the switching edge itself is not held off, so a change of pass-through can cut it.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pass_ff <= 1'b0;
      end else if (rx_st_ff == R_HUNT && tx_st_ff == T_IDLE && tl_st_ff == TL_ON) begin
         pass_ff <= passthru;
      end
   end

   // Transmit and transport registers.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tx_st_ff <= T_IDLE;
         th_ff <= '0;
         tcnt_ff <= 16'h0000;
         tl_st_ff <= TL_ON;
         rts_n_ff <= 1'b0;
         cts_d_ff <= 1'b1;
         pwr_ff <= uhf_pkg::power_state_uart_only;
      end else begin
         tx_st_ff <= nxt_tx_st;
         th_ff <= nxt_th;
         tcnt_ff <= nxt_tcnt;
         tl_st_ff <= nxt_tl_st;
         rts_n_ff <= nxt_rts_n;
         cts_d_ff <= cts_n;
         pwr_ff <= nxt_pwr;
      end
   end

   // Link supervision: a millisecond tick counts silence on a live link.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         tick_ff <= '0;
         ms_ff <= '0;
         lost_ff <= 1'b0;
         lost_p_ff <= 1'b0;
      end else begin
         tick_ff <= tick ? '0 : tick_ff + TW'(1);
         lost_p_ff <= 1'b0;
         if (!radio_link || remote_rx) begin
            ms_ff <= '0;
            lost_ff <= 1'b0;
         end else if (ms_full) begin
            lost_ff <= 1'b1;
            lost_p_ff <= !lost_ff;
         end else if (tick) begin
            ms_ff <= ms_ff + MW'(1);
         end
      end
   end

   // Configuration loads; unused codes are ignored and the old value kept.
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         lvl_ff <= uhf_pkg::EVLVL_DEFAULT;
         inq_ff <= uhf_pkg::INQ_DEFAULT;
      end else if (cfg_load) begin
         if (cfg_evlvl != 2'h3) lvl_ff <= uhf_pkg::uhf_evlvl_e'(cfg_evlvl);
         if (cfg_inq != 2'h3) inq_ff <= uhf_pkg::uhf_inq_e'(cfg_inq);
      end
   end

   // Outgoing bytes wait here while the UART is stalled or switched off.
   uhf_buf2 #(.W(8)) u_txbuf (
      .clock(clock),
      .rst(rst),
      .in_valid(b_in_valid),
      .in_data(b_in_data),
      .in_ready(b_in_ready),
      .out_valid(b_out_valid),
      .out_data(tx_data),
      .out_ready(tx_ready && uart_en)
   );
   assign tx_valid = b_out_valid && uart_en;
endmodule // uhf_framer
`default_nettype wire

/* uhf_framer_sva.sv */
// Port checker for the host command framer.
// Assumes one clock and an asynchronous active-high reset.
`default_nettype none
module uhf_framer_chk (
   input wire logic clock,
   input wire logic rst,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   input wire logic tx_ready,
   input wire logic uart_en,
   input wire logic cts_n,
   input wire logic hdr_valid,
   input wire uhf_pkg::uhf_hdr_s hdr,
   input wire logic frame_ok,
   input wire logic frame_err,
   input wire logic radio_scan,
   input wire logic radio_link,
   input wire uhf_pkg::uhf_power_e power_state,
   input wire logic slow_clk_ok,
   input wire logic link_lost
);
   // Reset aborts every attempt in flight.
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (rst);
   len_cap_a: assert property (hdr_valid |-> hdr.len <= uhf_pkg::MAX_PAYLOAD)
      else $error("header accepted with oversize length");
   end_pulse_a: assert property (!(frame_ok && frame_err))
      else $error("frame both good and bad");
   tx_hold_a: assert property (tx_valid && !tx_ready |=> tx_valid && $stable(tx_data))
      else $error("transmit byte changed while stalled");
   uart_off_a: assert property (!uart_en |-> !tx_valid && !rx_ready)
      else $error("traffic while transport off");
   slow_clk_a: assert property (slow_clk_ok == (power_state == uhf_pkg::power_state_scan_uart_off))
      else $error("slow clock outside scan with uart off");
   idle_state_a: assert property ((uart_en && !radio_scan && !radio_link) [*2] |->
      power_state == uhf_pkg::power_state_uart_only)
      else $error("wrong power state for uart only");
   link_pulse_a: assert property (link_lost |-> $past(radio_link) ##1 !link_lost)
      else $error("link loss pulse malformed");
   wake_up_a: assert property (!uart_en && $fell(cts_n) |-> ##[1:3] uart_en)
      else $error("falling host request did not wake transport");
   wake_c: cover property (!uart_en ##1 uart_en);
   bad_frame_c: cover property (frame_err);
   link_lost_c: cover property (link_lost);
endmodule // uhf_framer_chk
bind uhf_framer uhf_framer_chk CHK (.clock, .rst, .rx_ready, .tx_valid, .tx_data, .tx_ready, .uart_en, .cts_n,
   .hdr_valid, .hdr, .frame_ok, .frame_err, .radio_scan, .radio_link, .power_state, .slow_clk_ok, .link_lost);
`default_nettype wire

/* uhf_host_model.sv */
// Host processor on the far side of the UART byte streams.
// Assumes the bench fills send_q and reads seen_q by hierarchical name.
`default_nettype none
module uhf_host_model (
   input wire logic clock,
   input wire logic slow,
   output logic rx_valid,
   output logic [7:0] rx_data,
   input wire logic rx_ready,
   input wire logic tx_valid,
   input wire logic [7:0] tx_data,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] send_q[$]; // Bytes still to send, framed by the bench.
   logic [7:0] seen_q[$]; // Bytes received from the module.
   // A byte leaves only at a sampled handshake; idle data toggles so no stale byte looks valid.
   always @(posedge clock) begin
      if (rx_valid && rx_ready) void'(send_q.pop_front());
      if (tx_valid && tx_ready) seen_q.push_back(tx_data);
      #1;
      rx_valid = (send_q.size() != 0);
      rx_data = rx_valid ? send_q[0] : ~rx_data;
      tx_ready = !slow || !tx_ready; // A slow host accepts on alternate cycles at best.
   end
   initial begin
      rx_valid = 1'b0;
      rx_data = 8'h00;
      tx_ready = 1'b0;
   end
endmodule // uhf_host_model
`default_nettype wire

/* uhf_pkg.sv */
// Shared constants, types and helpers for the host command framer.
// Assumes one 20 MHz clock and byte-wide UART streams on both sides.
`default_nettype none
package uhf_pkg;
   // Frame delimiters.
   localparam logic [7:0] DELIM_START = 8'h02;
   localparam logic [7:0] DELIM_END = 8'h03;
   // Packet type byte values.
   localparam logic [7:0] TYPE_REQ = 8'h52;
   localparam logic [7:0] TYPE_CFM = 8'h43;
   localparam logic [7:0] TYPE_IND = 8'h69;
   localparam logic [7:0] TYPE_RES = 8'h72;
   // Largest payload a frame may carry.
   localparam logic [15:0] MAX_PAYLOAD = 16'h014D;
   // Opcodes of the two transport-layer frames; the values are arbitrary.
   localparam logic [7:0] OPC_DISABLE_TL = 8'h4F;
   localparam logic [7:0] OPC_TL_ENABLED = 8'h50;
   // Clock rate and the one-millisecond tick derived from it.
   localparam int CLK_HZ = 20_000_000;
   localparam int TICK_HZ = 1000;
   localparam int TICK_CYCLES = CLK_HZ / TICK_HZ;
   // Link supervision timeout in seconds, and the same in ticks.
   localparam int LINK_TIMEOUT_S = 20;
   localparam int LINK_TIMEOUT_MS = LINK_TIMEOUT_S * 1000;

   // Frame header as it travels between the framer and the command core.
   typedef struct packed {
      logic [7:0] ptype;
      logic [7:0] opcode;
      logic [15:0] len;
   } uhf_hdr_s;

   // Power states, from UART and radio activity.
   typedef enum logic [2:0] {
      power_state_all_off,
      power_state_uart_only,
      power_state_scan_uart_off,
      power_state_scan_uart_on,
      power_state_link_uart_off,
      power_state_link_uart_on
   } uhf_power_e;

   // Event reporting levels.
   typedef enum logic [1:0] {EV_NONE, EV_STD, EV_ALL} uhf_evlvl_e;
   localparam uhf_evlvl_e EVLVL_DEFAULT = EV_STD;

   // Inquiry-scan behaviour.
   typedef enum logic [1:0] {INQ_DISC, INQ_NONDISC, INQ_LIMITED} uhf_inq_e;
   localparam uhf_inq_e INQ_DEFAULT = INQ_DISC;

   // Header checksum: low byte of the sum of type, opcode and both length bytes.
   function automatic logic [7:0] hdr_sum(uhf_hdr_s h);
      return h.ptype + h.opcode + h.len[15:8] + h.len[7:0];
   endfunction
endpackage
`default_nettype wire
